// file: logic/ctrl_chan_pkg.sv
// Constants, types and record layout for the serial port control channel
`default_nettype none
package ctrl_chan_pkg;
	// Clock and password window
	localparam int CLK_HZ = 25_000_000;
	localparam int PW_TIMEOUT_MS = 2000;
	localparam int PW_TIMEOUT_CYC = (CLK_HZ / 1000) * PW_TIMEOUT_MS;
	localparam int PW_MAX = 8;
	// Record size and byte offsets, low byte of each word first
	localparam logic [4:0] REC_LEN = 5'h1e;
	localparam logic [4:0] REC_LAST = 5'h1d;
	localparam logic [4:0] REC_CNT_MAX = 5'h1f;
	localparam logic [4:0] OFS_ERR_LO = 5'h01;
	localparam logic [4:0] OFS_ERR_HI = 5'h02;
	localparam logic [4:0] OFS_FLG_LO = 5'h03;
	localparam logic [4:0] OFS_FLG_HI = 5'h04;
	localparam logic [4:0] OFS_RXC_LO = 5'h05;
	localparam logic [4:0] OFS_RXC_HI = 5'h06;
	localparam logic [4:0] OFS_TXC_LO = 5'h07;
	localparam logic [4:0] OFS_TXC_HI = 5'h08;
	// Error word bit positions
	localparam int ERR_PORT = 3;
	localparam int ERR_BREAK = 4;
	localparam int ERR_CTS = 5;
	localparam int ERR_DSR = 6;
	localparam int ERR_CD = 7;
	localparam int ERR_PAR = 8;
	localparam int ERR_FRM = 9;
	localparam int ERR_RXOVR = 14;
	// Line flags (low byte) and command flags (within the high byte)
	localparam int FL_CTS = 0;
	localparam int FL_DSR = 1;
	localparam int FL_RING = 2;
	localparam int FL_CD = 3;
	localparam int FL_DTR = 4;
	localparam int FL_RTS = 5;
	localparam int CMD_XOFF = 1;
	localparam int CMD_FLUSH_RX = 2;
	localparam int CMD_FLUSH_TX = 3;
	localparam int CMD_SET_LINES = 4;
	localparam int CMD_SET_BRK = 5;
	localparam int CMD_CLR_BRK = 6;
	// Control connection port numbers per serial port
	localparam logic [15:0] CTRL_PORT_A = 16'h2386;
	localparam logic [15:0] CTRL_PORT_B = 16'h23ea;
	localparam logic [15:0] CTRL_PORT_C = 16'h244e;
	// Index of the last failure message byte, the terminator after the text
	localparam logic [2:0] FAIL_LAST = 3'h7;
	// Register addresses
	localparam logic [3:0] REG_CTRL_PORT = 4'h0;
	localparam logic [3:0] REG_MODE = 4'h1;
	localparam logic [3:0] REG_PW_LEN = 4'h2;
	localparam logic [3:0] REG_PW_LO = 4'h3;
	localparam logic [3:0] REG_PW_HI = 4'h4;
	localparam logic [3:0] REG_ERR = 4'h5;
	localparam logic [3:0] REG_STATUS = 4'h6;
	localparam int MODE_SERVER = 0;
	localparam int MODE_TUNNEL = 1;

	// Error events from the serial engine, one-cycle pulses
	typedef struct packed {
		logic port_err;
		logic brk;
		logic cts_to;
		logic dsr_to;
		logic cd_to;
		logic parity;
		logic frame;
	} err_event_t;

	// Modem inputs from the pins
	typedef struct packed {
		logic cts;
		logic dsr;
		logic ring_state;
		logic cd;
	} modem_in_t;

	// Snapshot taken when a record is sent
	typedef struct packed {
		logic [15:0] err;
		logic [15:0] flags;
		logic [15:0] rx_fill_count;
		logic [15:0] tx_fill_count;
	} status_rec_t;

	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef enum logic [2:0] {
		ST_CLOSED,
		ST_AUTH,
		ST_COLLECT,
		ST_REPLY,
		ST_FAIL,
		ST_DROP
	} ctrl_state_t;

	// Default control port for serial port 0, 1 or 2
	function automatic logic [15:0] ctrl_port_default(input logic [1:0] idx);
		case (idx)
			2'h1: ctrl_port_default = CTRL_PORT_B;
			2'h2: ctrl_port_default = CTRL_PORT_C;
			default: ctrl_port_default = CTRL_PORT_A;
		endcase
	endfunction

	// Byte of the status record at a given offset
	function automatic logic [7:0] rec_byte(input logic [4:0] idx, input status_rec_t s);
		case (idx)
			OFS_ERR_LO: rec_byte = s.err[7:0];
			OFS_ERR_HI: rec_byte = s.err[15:8];
			OFS_FLG_LO: rec_byte = s.flags[7:0];
			OFS_FLG_HI: rec_byte = s.flags[15:8];
			OFS_RXC_LO: rec_byte = s.rx_fill_count[7:0];
			OFS_RXC_HI: rec_byte = s.rx_fill_count[15:8];
			OFS_TXC_LO: rec_byte = s.tx_fill_count[7:0];
			OFS_TXC_HI: rec_byte = s.tx_fill_count[15:8];
			default: rec_byte = 8'h00;
		endcase
	endfunction

	// Failure text with its zero terminator
	function automatic logic [7:0] fail_byte(input logic [2:0] idx);
		case (idx)
			3'h0: fail_byte = 8'h50;
			3'h1: fail_byte = 8'h41;
			3'h2: fail_byte = 8'h53;
			3'h3: fail_byte = 8'h53;
			3'h4: fail_byte = 8'h57;
			3'h5: fail_byte = 8'h44;
			3'h6: fail_byte = 8'h3f;
			default: fail_byte = 8'h00;
		endcase
	endfunction
endpackage
`default_nettype wire

// file: logic/pin_sync.sv
// Two flip-flop synchroniser for a group of asynchronous pins
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 4
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r; // First stage, read only by the second

	// Both stages reset to zero so outputs are defined from reset
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_r <= '0;
			sync_out <= '0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule // pin_sync
`default_nettype wire

// file: logic/ctrl_channel.sv
// Control connection command interpreter for one serial port
//
// Notes on behaviour
// - Control link carries only status and commands
// - Control port number configurable, per-port defaults
// - Accept control link only in server mode
// - Data and control links open independently
// - Failed password: send failure text, then close
// - No password: records accepted immediately
// - Any received packet gets a full status record
// - Incomplete record: status reply, no command
// - Records are 30 bytes, zero framed
// - Error word reports line and port errors
// - Overrun flag set on overflow after stop
// - Status block: flags, rx count, tx count
// - Low flag bits show lines, refreshed per record
// - Command flags send stop, flush input, flush output
// - Line command drives RTS and DTR from record
// - Break set and clear are separate flags; clear wins when both are set
// - Ring buffer fill counts reported as words
// - Only flags equal to one execute
// - Break holds serial output low until cleared
`default_nettype none
module ctrl_channel #(
	parameter logic [1:0] PORT_INDEX = 2'h0,
	parameter int PW_TIMEOUT_CYC = ctrl_chan_pkg::PW_TIMEOUT_CYC
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire ctrl_chan_pkg::reg_req_t reg_req_in,
	output logic [31:0] reg_rdata_out,
	input wire logic conn_open_in,
	input wire logic rx_valid_in,
	input wire logic [7:0] rx_data_in,
	input wire logic rx_last_in,
	output logic rx_ready_out,
	output logic tx_valid_out,
	output logic [7:0] tx_data_out,
	input wire logic tx_ready_in,
	output logic conn_close_out,
	input wire ctrl_chan_pkg::modem_in_t modem_in,
	input wire ctrl_chan_pkg::err_event_t err_event_in,
	input wire logic rx_overflow_in,
	input wire logic flow_stopped_in,
	input wire logic [15:0] rx_fill_count_in,
	input wire logic [15:0] tx_fill_count_in,
	input wire logic txd_in,
	output logic txd_out,
	output logic rts_out,
	output logic dtr_out,
	output logic break_mode_out,
	output logic send_xoff_out,
	output logic flush_rx_out,
	output logic flush_tx_out
);
	ctrl_chan_pkg::ctrl_state_t state_r; // Connection state
	ctrl_chan_pkg::status_rec_t snap_r; // Record being sent
	ctrl_chan_pkg::modem_in_t modem_s; // Synchronised modem lines
	logic [15:0] ctrl_port_r; // Listening port number
	logic [1:0] mode_r; // Server enable and tunnel mode
	logic [3:0] pw_len_r; // Password length, zero when none
	logic [63:0] pw_r; // Password bytes, first in low byte
	logic [15:0] err_r; // Sticky error word
	logic open_q; // Previous connection level
	logic [31:0] timer_r; // Password window counter
	logic [3:0] pw_idx_r; // Bytes matched so far
	logic pw_ok_r; // No mismatch yet
	logic [4:0] pkt_cnt_r; // Bytes in current packet, saturating
	logic first_zero_r; // First byte was zero
	logic [7:0] flg_lo_r; // Stored line bits of a command
	logic [7:0] flg_hi_r; // Stored command flags
	logic [4:0] tx_idx_r; // Byte index of outgoing record
	logic [7:0] tx_data_r; // Outgoing byte
	logic close_r; // Close request pulse
	logic brk_r; // Break mode
	logic rts_r; // RTS drive
	logic dtr_r; // DTR drive
	logic xoff_r; // Stop character request
	logic flush_rx_r; // Input discard request
	logic flush_tx_r; // Output discard request
	logic txd_r; // Serial data after break gating
	logic [31:0] rdata_r; // Read data, one cycle after strobe

	logic open_rise; // Connection just established
	logic allowed; // Port may serve a control link
	logic rx_fire; // Byte taken from the link
	logic tx_fire; // Byte accepted by the link
	logic [4:0] cnt_nxt; // Packet length including this byte
	logic pkt_end; // Last byte of a packet in collection
	logic complete; // Packet is one whole framed record
	logic exec; // Execute the stored command flags
	logic [7:0] pw_byte; // Expected password byte
	logic [15:0] flags_now; // Live line flags word

	// Modem pins come from outside the clock domain
	pin_sync #(
		.WIDTH(4)
	) u_modem_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.async_in(modem_in),
		.sync_out(modem_s)
	);

	// Control service only as plain server, never in tunnel mode
	assign allowed = mode_r[ctrl_chan_pkg::MODE_SERVER] && !mode_r[ctrl_chan_pkg::MODE_TUNNEL];
	assign open_rise = conn_open_in && !open_q;
	// Only the control link is handled here; payload stays on the data path
	assign rx_ready_out = (state_r == ctrl_chan_pkg::ST_AUTH) ||
		(state_r == ctrl_chan_pkg::ST_COLLECT);
	assign rx_fire = rx_valid_in && rx_ready_out;
	assign tx_valid_out = (state_r == ctrl_chan_pkg::ST_REPLY) || (state_r == ctrl_chan_pkg::ST_FAIL);
	assign tx_fire = tx_valid_out && tx_ready_in;
	assign tx_data_out = tx_data_r;
	assign cnt_nxt = (pkt_cnt_r == ctrl_chan_pkg::REC_CNT_MAX) ? pkt_cnt_r : pkt_cnt_r + 5'h01;
	assign pkt_end = (state_r == ctrl_chan_pkg::ST_COLLECT) && rx_fire && rx_last_in;
	// Whole record: exactly 30 bytes, zero first and last byte
	assign complete = (cnt_nxt == ctrl_chan_pkg::REC_LEN) && first_zero_r &&
		(rx_data_in == 8'h00);
	assign exec = pkt_end && complete;
	assign pw_byte = pw_r[{pw_idx_r[2:0], 3'h0} +: 8];
	// Line flags refreshed live; captured anew for every record
	assign flags_now = {8'h00, 2'h0, rts_r, dtr_r, modem_s.cd, modem_s.ring_state,
		modem_s.dsr, modem_s.cts};
	assign conn_close_out = close_r;
	assign txd_out = txd_r;
	assign rts_out = rts_r;
	assign dtr_out = dtr_r;
	assign break_mode_out = brk_r;
	assign send_xoff_out = xoff_r;
	assign flush_rx_out = flush_rx_r;
	assign flush_tx_out = flush_tx_r;
	assign reg_rdata_out = rdata_r;

	// Software-written configuration; the data link is not touched here
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_port_r <= ctrl_chan_pkg::ctrl_port_default(PORT_INDEX);
			mode_r <= 2'h1;
			pw_len_r <= 4'h0;
			pw_r <= 64'h0;
		end else if (reg_req_in.wr) begin
			case (reg_req_in.addr)
				ctrl_chan_pkg::REG_CTRL_PORT: ctrl_port_r <= reg_req_in.wdata[15:0];
				ctrl_chan_pkg::REG_MODE: mode_r <= reg_req_in.wdata[1:0];
				// Lengths above the store are clipped to it
				ctrl_chan_pkg::REG_PW_LEN: pw_len_r <= (reg_req_in.wdata[3:0] > 4'h8) ?
					4'h8 : reg_req_in.wdata[3:0];
				ctrl_chan_pkg::REG_PW_LO: pw_r[31:0] <= reg_req_in.wdata;
				ctrl_chan_pkg::REG_PW_HI: pw_r[63:32] <= reg_req_in.wdata;
				default: ;
			endcase
		end
	end

	// Register reads answer in the next cycle; unmapped reads give zero
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_r <= 32'h0;
		end else if (reg_req_in.rd) begin
			case (reg_req_in.addr)
				ctrl_chan_pkg::REG_CTRL_PORT: rdata_r <= {16'h0, ctrl_port_r};
				ctrl_chan_pkg::REG_MODE: rdata_r <= {30'h0, mode_r};
				ctrl_chan_pkg::REG_PW_LEN: rdata_r <= {28'h0, pw_len_r};
				ctrl_chan_pkg::REG_PW_LO: rdata_r <= pw_r[31:0];
				ctrl_chan_pkg::REG_PW_HI: rdata_r <= pw_r[63:32];
				ctrl_chan_pkg::REG_ERR: rdata_r <= {16'h0, err_r};
				ctrl_chan_pkg::REG_STATUS: rdata_r <= {27'h0, state_r == ctrl_chan_pkg::ST_COLLECT,
					allowed, dtr_r, rts_r, brk_r};
				default: rdata_r <= 32'h0;
			endcase
		end else begin
			rdata_r <= 32'h0;
		end
	end

	// Sticky error word; a new event beats a same-cycle clear
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			err_r <= 16'h0;
		end else begin
			err_r <= (err_r & ~((reg_req_in.wr && reg_req_in.addr == ctrl_chan_pkg::REG_ERR) ?
				reg_req_in.wdata[15:0] : 16'h0)) |
				(16'(err_event_in.port_err) << ctrl_chan_pkg::ERR_PORT) |
				(16'(err_event_in.brk) << ctrl_chan_pkg::ERR_BREAK) |
				(16'(err_event_in.cts_to) << ctrl_chan_pkg::ERR_CTS) |
				(16'(err_event_in.dsr_to) << ctrl_chan_pkg::ERR_DSR) |
				(16'(err_event_in.cd_to) << ctrl_chan_pkg::ERR_CD) |
				(16'(err_event_in.parity) << ctrl_chan_pkg::ERR_PAR) |
				(16'(err_event_in.frame) << ctrl_chan_pkg::ERR_FRM) |
				(16'(rx_overflow_in && flow_stopped_in) << ctrl_chan_pkg::ERR_RXOVR);
		end
	end

	// Connection sequencing; runs without regard to the data link
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= ctrl_chan_pkg::ST_CLOSED;
			open_q <= 1'b0;
			close_r <= 1'b0;
		end else begin
			open_q <= conn_open_in;
			close_r <= 1'b0;
			if (!conn_open_in) begin
				state_r <= ctrl_chan_pkg::ST_CLOSED;
			end else begin
				case (state_r)
					ctrl_chan_pkg::ST_CLOSED: begin
						if (open_rise && !allowed) begin
							close_r <= 1'b1;
							state_r <= ctrl_chan_pkg::ST_DROP;
						end else if (open_rise) begin
							// No password: go straight to record exchange
							state_r <= (pw_len_r == 4'h0) ? ctrl_chan_pkg::ST_COLLECT :
								ctrl_chan_pkg::ST_AUTH;
						end
					end
					ctrl_chan_pkg::ST_AUTH: begin
						if (timer_r == 32'(PW_TIMEOUT_CYC - 1)) begin
							state_r <= ctrl_chan_pkg::ST_FAIL;
						end else if (rx_fire && rx_data_in == 8'h00) begin
							state_r <= (pw_ok_r && pw_idx_r == pw_len_r) ?
								ctrl_chan_pkg::ST_COLLECT : ctrl_chan_pkg::ST_FAIL;
						end
					end
					ctrl_chan_pkg::ST_COLLECT: begin
						if (pkt_end) begin
							state_r <= ctrl_chan_pkg::ST_REPLY;
						end
					end
					ctrl_chan_pkg::ST_REPLY: begin
						if (tx_fire && tx_idx_r == ctrl_chan_pkg::REC_LAST) begin
							state_r <= ctrl_chan_pkg::ST_COLLECT;
						end
					end
					ctrl_chan_pkg::ST_FAIL: begin
						if (tx_fire && tx_idx_r[2:0] == ctrl_chan_pkg::FAIL_LAST) begin
							close_r <= 1'b1;
							state_r <= ctrl_chan_pkg::ST_DROP;
						end
					end
					// Wait for the link to go down after a close
					ctrl_chan_pkg::ST_DROP: ;
					default: state_r <= ctrl_chan_pkg::ST_CLOSED;
				endcase
			end
		end
	end

	// Password window and exact byte comparison
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			timer_r <= 32'h0;
			pw_idx_r <= 4'h0;
			pw_ok_r <= 1'b1;
		end else if (state_r != ctrl_chan_pkg::ST_AUTH) begin
			timer_r <= 32'h0;
			pw_idx_r <= 4'h0;
			pw_ok_r <= 1'b1;
		end else begin
			timer_r <= timer_r + 32'h1;
			if (rx_fire && rx_data_in != 8'h00) begin
				// Extra bytes beyond the stored length count as mismatch
				if (pw_idx_r == pw_len_r || rx_data_in != pw_byte) begin
					pw_ok_r <= 1'b0;
				end else begin
					pw_idx_r <= pw_idx_r + 4'h1;
				end
			end
		end
	end

	// Packet gathering; only the command words of a record are kept
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pkt_cnt_r <= 5'h0;
			first_zero_r <= 1'b0;
			flg_lo_r <= 8'h0;
			flg_hi_r <= 8'h0;
		end else if (state_r != ctrl_chan_pkg::ST_COLLECT || pkt_end) begin
			pkt_cnt_r <= 5'h0;
		end else if (rx_fire) begin
			pkt_cnt_r <= cnt_nxt;
			if (pkt_cnt_r == 5'h0) begin
				first_zero_r <= (rx_data_in == 8'h00);
			end
			if (pkt_cnt_r == ctrl_chan_pkg::OFS_FLG_LO) begin
				flg_lo_r <= rx_data_in;
			end
			if (pkt_cnt_r == ctrl_chan_pkg::OFS_FLG_HI) begin
				flg_hi_r <= rx_data_in;
			end
		end
	end

	// Command execution; a flag acts only when it is one
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			xoff_r <= 1'b0;
			flush_rx_r <= 1'b0;
			flush_tx_r <= 1'b0;
			rts_r <= 1'b0;
			dtr_r <= 1'b0;
			brk_r <= 1'b0;
		end else begin
			xoff_r <= exec && flg_hi_r[ctrl_chan_pkg::CMD_XOFF];
			flush_rx_r <= exec && flg_hi_r[ctrl_chan_pkg::CMD_FLUSH_RX];
			flush_tx_r <= exec && flg_hi_r[ctrl_chan_pkg::CMD_FLUSH_TX];
			if (exec && flg_hi_r[ctrl_chan_pkg::CMD_SET_LINES]) begin
				rts_r <= flg_lo_r[ctrl_chan_pkg::FL_RTS];
				dtr_r <= flg_lo_r[ctrl_chan_pkg::FL_DTR];
			end
			// Clear is checked before set, so both at once leaves break off
			if (exec && flg_hi_r[ctrl_chan_pkg::CMD_CLR_BRK]) begin
				brk_r <= 1'b0;
			end else if (exec && flg_hi_r[ctrl_chan_pkg::CMD_SET_BRK]) begin
				brk_r <= 1'b1;
			end
		end
	end

	// Break drives the line to space for as long as it lasts
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			txd_r <= 1'b1;
		end else begin
			txd_r <= brk_r ? 1'b0 : txd_in;
		end
	end

	// Outgoing bytes; the snapshot is taken when a reply starts
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			snap_r <= '0;
			tx_idx_r <= 5'h0;
			tx_data_r <= 8'h0;
		end else if (pkt_end) begin
			snap_r <= '{err: err_r, flags: flags_now, rx_fill_count: rx_fill_count_in,
				tx_fill_count: tx_fill_count_in};
			tx_idx_r <= 5'h0;
			tx_data_r <= 8'h00;
		end else if (state_r == ctrl_chan_pkg::ST_AUTH) begin
			tx_idx_r <= 5'h0;
			tx_data_r <= ctrl_chan_pkg::fail_byte(3'h0);
		end else if (tx_fire) begin
			tx_idx_r <= tx_idx_r + 5'h01;
			tx_data_r <= (state_r == ctrl_chan_pkg::ST_FAIL) ?
				ctrl_chan_pkg::fail_byte(tx_idx_r[2:0] + 3'h1) :
				ctrl_chan_pkg::rec_byte(tx_idx_r + 5'h01, snap_r);
		end
	end

	sequence s_pkt_done;
		state_r == ctrl_chan_pkg::ST_COLLECT && rx_fire && rx_last_in;
	endsequence

	a_refuse_tunnel: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state_r == ctrl_chan_pkg::ST_CLOSED && open_rise && !allowed |=> close_r && !rx_ready_out)
		else $error("control link accepted outside server mode");
	a_nopw_ready: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state_r == ctrl_chan_pkg::ST_CLOSED && open_rise && allowed && pw_len_r == 4'h0
		|=> state_r == ctrl_chan_pkg::ST_COLLECT)
		else $error("records not accepted at once without password");
	a_reply_follows: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		s_pkt_done ##1 conn_open_in |-> tx_valid_out && tx_data_out == 8'h00)
		else $error("no record after a received packet");
	a_partial_noexec: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		s_pkt_done and !complete |=> !xoff_r && !flush_rx_r && !flush_tx_r && $stable(brk_r))
		else $error("command executed from incomplete record");
	a_frame_last: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state_r == ctrl_chan_pkg::ST_REPLY && tx_idx_r == ctrl_chan_pkg::REC_LAST
		|-> tx_data_out == 8'h00)
		else $error("record not closed by zero byte");
	a_fail_close: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state_r == ctrl_chan_pkg::ST_FAIL && tx_fire && tx_idx_r[2:0] == ctrl_chan_pkg::FAIL_LAST
		|-> tx_data_out == 8'h00 ##1 close_r)
		else $error("failure text not ended and closed");
	a_pw_window: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state_r == ctrl_chan_pkg::ST_AUTH && timer_r == 32'(PW_TIMEOUT_CYC - 1) && conn_open_in
		|=> state_r == ctrl_chan_pkg::ST_FAIL)
		else $error("password window not enforced");
	a_lines_cmd: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		exec && flg_hi_r[ctrl_chan_pkg::CMD_SET_LINES]
		|=> rts_out == $past(flg_lo_r[ctrl_chan_pkg::FL_RTS]) &&
		dtr_out == $past(flg_lo_r[ctrl_chan_pkg::FL_DTR]))
		else $error("modem lines not driven from record");
	a_break_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		exec && flg_hi_r[ctrl_chan_pkg::CMD_SET_BRK] && !flg_hi_r[ctrl_chan_pkg::CMD_CLR_BRK]
		|=> brk_r ##1 !txd_out)
		else $error("break mode not entered or line not held");
	a_overrun_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rx_overflow_in && flow_stopped_in |=> err_r[ctrl_chan_pkg::ERR_RXOVR])
		else $error("overrun after stop not flagged");
endmodule // ctrl_channel
`default_nettype wire

// file: verification/client_model.sv
// Remote client model for the control connection
`default_nettype none
module client_model (
	input wire logic clk_in,
	input wire logic rx_ready_in,
	input wire logic tx_valid_in,
	input wire logic [7:0] tx_data_in,
	output logic conn_open_out,
	output logic rx_valid_out,
	output logic [7:0] rx_data_out,
	output logic rx_last_out,
	output logic tx_ready_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rec [30]; // Bytes of the last reply
	int got = 0; // Bytes taken by the last receive
	logic rdy_q, vq;
	logic [7:0] dq;
	initial begin
		conn_open_out = 1'b0;
		rx_valid_out = 1'b0;
		rx_data_out = 8'hff;
		rx_last_out = 1'b0;
		tx_ready_out = 1'b0;
	end
	// Handshake inputs sampled mid-cycle, where they have settled
	always @(negedge clk_in) begin
		rdy_q = rx_ready_in;
		vq = tx_valid_in;
		dq = tx_data_in;
	end
	task automatic connect(input logic v);
		conn_open_out <= v;
		repeat (2) @(posedge clk_in);
	endtask
	// One packet, each byte held until taken; the released line shows junk
	task automatic send(input logic [7:0] b [30], input int n);
		for (int i = 0; i < n; i++) begin
			rx_valid_out <= 1'b1;
			rx_data_out <= b[i];
			rx_last_out <= (i == n - 1);
			do @(posedge clk_in); while (!rdy_q);
		end
		rx_valid_out <= 1'b0;
		rx_last_out <= 1'b0;
		rx_data_out <= ~rx_data_out;
	endtask
	// Collect n bytes, stalling one cycle in four
	task automatic recv(input int n);
		int k;
		k = 0;
		for (int c = 0; c < 400 && k < n; c++) begin
			tx_ready_out <= (c % 4) != 0;
			@(posedge clk_in);
			if (vq && tx_ready_out) begin
				rec[k] = dq;
				k++;
			end
		end
		tx_ready_out <= 1'b0;
		got = k;
	endtask
endmodule // client_model
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the control channel interpreter
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	ctrl_chan_pkg::reg_req_t req = '0;
	ctrl_chan_pkg::modem_in_t modem = 4'ha; // CTS and ring high
	ctrl_chan_pkg::err_event_t ev = '0;
	logic ovf = 1'b0;
	logic fstop = 1'b0;
	logic [15:0] rxc = 16'h1234; // Live receive fill count
	logic [15:0] txc = 16'h00ab; // Live transmit fill count
	logic txd_i = 1'b1; // Serial data into the break gate
	logic [31:0] rdata;
	logic rx_v, rx_l, rx_rdy, tx_v, tx_rdy, conn, close, txd, rts, dtr, brk, xoff, frx, ftx;
	logic [7:0] rx_d, tx_d;
	logic [7:0] pk [30]; // Packet to send
	int bad_count = 0;
	int samples_checked = 0;
	int cyc = 0, n_xoff = 0, n_frx = 0, n_ftx = 0, n_close = 0;
	always #20 clk_in = ~clk_in;
	// Short password window keeps the run brief
	ctrl_channel #(.PORT_INDEX(2'h0), .PW_TIMEOUT_CYC(200)) dut (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_req_in(req), .reg_rdata_out(rdata),
		.conn_open_in(conn), .rx_valid_in(rx_v), .rx_data_in(rx_d), .rx_last_in(rx_l),
		.rx_ready_out(rx_rdy), .tx_valid_out(tx_v), .tx_data_out(tx_d), .tx_ready_in(tx_rdy),
		.conn_close_out(close), .modem_in(modem), .err_event_in(ev),
		.rx_overflow_in(ovf), .flow_stopped_in(fstop), .rx_fill_count_in(rxc),
		.tx_fill_count_in(txc), .txd_in(txd_i), .txd_out(txd), .rts_out(rts),
		.dtr_out(dtr), .break_mode_out(brk), .send_xoff_out(xoff), .flush_rx_out(frx),
		.flush_tx_out(ftx));
	client_model cl (.clk_in(clk_in), .rx_ready_in(rx_rdy), .tx_valid_in(tx_v),
		.tx_data_in(tx_d), .conn_open_out(conn), .rx_valid_out(rx_v), .rx_data_out(rx_d),
		.rx_last_out(rx_l), .tx_ready_out(tx_rdy));
	// One-cycle pulses are counted mid-cycle; a hang is cut short here
	always @(negedge clk_in) begin
		n_xoff += xoff;
		n_frx += frx;
		n_ftx += ftx;
		n_close += close;
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			end_sim();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_in);
		req <= '0;
		@(posedge clk_in);
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_in);
		req <= '0;
		@(negedge clk_in);
		chk("reg read", e, rdata);
		@(posedge clk_in);
	endtask
	task automatic xfer(input int n, input int m);
		cl.send(pk, n);
		cl.recv(m);
	endtask
	// Whole record: zero frame, error word, flags, fill counts, low byte first
	task automatic chk_rec(input logic [15:0] err, input logic [7:0] fl);
		logic [7:0] e [30];
		e = '{default: 8'h00};
		{e[2], e[1]} = err;
		e[3] = fl;
		{e[6], e[5]} = rxc;
		{e[8], e[7]} = txc;
		chk("rec len", 32'd30, cl.got);
		for (int i = 0; i < 30; i++) chk("rec byte", {24'h0, e[i]}, {24'h0, cl.rec[i]});
	endtask
	// Failure text, then the close pulse
	task automatic chk_fail(input int nc);
		logic [63:0] t;
		t = 64'h5041535357443f00;
		repeat (2) @(posedge clk_in);
		@(negedge clk_in);
		chk("closes", nc, n_close);
		chk("fail len", 32'd8, cl.got);
		for (int i = 0; i < 8; i++) chk("fail byte", {24'h0, t[63 - 8 * i -: 8]}, {24'h0, cl.rec[i]});
		@(posedge clk_in);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		pk = '{default: 8'h00};
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		rd(ctrl_chan_pkg::REG_CTRL_PORT, 32'h0000_2386);
		rd(ctrl_chan_pkg::REG_MODE, 32'h0000_0001);
		rd(4'hf, 32'h0000_0000);
		cl.connect(1'b1);
		xfer(1, 30);
		chk_rec(16'h0000, 8'h05);
		// Overflow alone is not an overrun; only after flow stop
		ovf <= 1'b1;
		@(posedge clk_in);
		fstop <= 1'b1;
		ev <= '1;
		@(posedge clk_in);
		ev <= '0;
		ovf <= 1'b0;
		@(posedge clk_in);
		xfer(1, 30);
		chk_rec(16'h43f8, 8'h05);
		rd(ctrl_chan_pkg::REG_ERR, 32'h0000_43f8);
		wr(ctrl_chan_pkg::REG_ERR, 32'h0000_ffff);
		rd(ctrl_chan_pkg::REG_ERR, 32'h0000_0000);
		// Partial record carrying commands must do nothing
		pk[3] = 8'h30;
		pk[4] = 8'h3e;
		xfer(10, 30);
		chk_rec(16'h0000, 8'h05);
		xfer(30, 30);
		chk_rec(16'h0000, 8'h05);
		@(negedge clk_in);
		chk("lines brk txd", 32'he, {rts, dtr, brk, txd});
		chk("pulses", 32'h111, {n_xoff[3:0], n_frx[3:0], n_ftx[3:0]});
		@(posedge clk_in);
		rd(ctrl_chan_pkg::REG_STATUS, 32'h0000_001f);
		// Bad frame byte: clear-break ignored
		pk[0] = 8'h01;
		pk[3] = 8'h00;
		pk[4] = 8'h40;
		xfer(30, 30);
		chk_rec(16'h0000, 8'h35);
		@(negedge clk_in);
		chk("framed", 32'h1, brk);
		@(posedge clk_in);
		pk[0] = 8'h00;
		xfer(30, 30);
		chk_rec(16'h0000, 8'h35);
		@(negedge clk_in);
		chk("after clear", 32'hd, {rts, dtr, brk, txd});
		chk("pulses", 32'h111, {n_xoff[3:0], n_frx[3:0], n_ftx[3:0]});
		@(posedge clk_in);
		// Outside break the serial data must pass straight through
		txd_i <= 1'b0;
		cl.connect(1'b0);
		wr(ctrl_chan_pkg::REG_MODE, 32'h0000_0003);
		cl.connect(1'b1);
		@(negedge clk_in);
		chk("refused", 32'h2, {n_close[3:0], rx_rdy});
		chk("txd pass", 32'h0, txd);
		@(posedge clk_in);
		cl.connect(1'b0);
		wr(ctrl_chan_pkg::REG_MODE, 32'h0000_0001);
		wr(ctrl_chan_pkg::REG_PW_LEN, 32'h0000_0002);
		wr(ctrl_chan_pkg::REG_PW_LO, 32'h0000_4241);
		// New line states and fill counts must show in the next record
		modem <= 4'h5;
		rxc <= 16'h0102;
		txc <= 16'hbeef;
		cl.connect(1'b1);
		pk[0] = 8'h41;
		pk[1] = 8'h42;
		cl.send(pk, 3);
		@(posedge clk_in);
		xfer(1, 30);
		chk_rec(16'h0000, 8'h3a);
		cl.connect(1'b0);
		cl.connect(1'b1);
		pk[1] = 8'h43;
		xfer(3, 8);
		chk_fail(2);
		cl.connect(1'b0);
		cl.connect(1'b1);
		cl.recv(8);
		chk_fail(3);
		end_sim();
	end
endmodule // tb
`default_nettype wire
